/* logic/oic_pkg.sv */
// Package of constants for the output interface configuration registers
package oic_pkg;
  // ==========================================================================
  // Frame layout
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned ADDR_BITS      = 12;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned RW_BIT         = 23;
  // ==========================================================================
  // Register offsets
  localparam logic [11:0] SOFT_RESET_OFS = 12'h000;
  localparam logic [11:0] OUT_IF_OFS     = 12'h007;
  localparam logic [11:0] PWR_DOWN_OFS   = 12'h008;
  localparam logic [11:0] FUSE_LOAD_OFS  = 12'h013;
  // ==========================================================================
  // Field positions
  localparam int unsigned RESET_BIT      = 0;
  localparam int unsigned FUSE_LOAD_BIT  = 0;
  localparam int unsigned MAP_HI         = 7;
  localparam int unsigned MAP_LO         = 5;
  localparam int unsigned OVR_EN_BIT     = 3;
  localparam int unsigned SEL_HI         = 2;
  localparam int unsigned SEL_LO         = 0;
  localparam int unsigned PD_GLOBAL_BIT  = 0;
  localparam int unsigned PD_CHAN_BIT    = 2;
  localparam int unsigned PD_REFAMP_BIT  = 4;
  localparam int unsigned PD_CLKBUF_BIT  = 5;
  // ==========================================================================
  // Reset values and power-down write mask
  localparam logic [7:0] OUT_IF_RST      = 8'h00;
  localparam logic [7:0] PWR_DOWN_RST    = 8'h02;
  localparam logic [7:0] PWR_DOWN_WMASK  = 8'h35;
  // ==========================================================================
  // Format select codes
  localparam logic [2:0] FMT_SDR         = 3'h0;
  localparam logic [2:0] FMT_DDR         = 3'h1;
  localparam logic [2:0] FMT_TWO_WIRE    = 3'h3;
  localparam logic [2:0] FMT_ONE_WIRE    = 3'h4;
  localparam logic [2:0] FMT_HALF_WIRE   = 3'h5;
  // Lane mapping codes
  localparam logic [2:0] MAP_TWO_18      = 3'h1;
  localparam logic [2:0] MAP_TWO_16      = 3'h2;
  localparam logic [2:0] MAP_ONE         = 3'h3;
  localparam logic [2:0] MAP_HALF        = 3'h4;
  localparam logic [2:0] MAP_DDR         = 3'h5;
  localparam logic [2:0] MAP_SDR         = 3'h6;
endpackage : oic_pkg

/* logic/oic_regs.sv */
// Output interface configuration register bank behind a 24-bit serial port
//
// Operation
// RQ1 - Writing one to soft-reset bit 0 restores all defaults, bit self-clears; code keeps the latched lane mapping.
// RQ2 - Lane mapping lives in bits 7:5 with codes 001 through 110.
// RQ3 - A new lane mapping applies only after the fuse load command.
// RQ4 - Host writes output interface and fuse load before other writes.
// RQ5 - After reset the fuse default interface loads automatically.
// RQ6 - Mapping and format read zero until written over the serial port.
// RQ7 - Override enable bit 3 lets format select replace fuse default.
// RQ8 - Format codes: SDR, DDR, two-wire, one-wire, half-wire; others unused.
// RQ9 - Format select acts only while override enable is set.
// RQ10 - Bits shift in while select low; update on each 24th rising edge.
// RQ11 - Global power-down bit 0 powers down the masked internal blocks.
// RQ12 - Channel power-down bit 2 powers down the channel when set.
// RQ13 - Host writes zero to reserved bits and avoids unused codes.
`timescale 1ns/10ps
`default_nettype none
module oic_regs
  import oic_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Serial port, sampled synchronously
  input  wire logic       serial_select_n,
  input  wire logic       sclk,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe,
  // Fuse defaults
  input  wire logic [2:0] fuse_format,
  input  wire logic [2:0] fuse_mapping,
  input  wire logic [2:0] powerdown_mask,
  // Effective configuration
  output logic [2:0]      active_format,
  output logic [2:0]      active_mapping,
  output logic            global_powerdown,
  output logic            channel_powerdown,
  output logic            clock_buffer_powerdown,
  output logic            reference_amp_powerdown,
  output logic            pd_clkbuf_blk,
  output logic            pd_refamp_blk,
  output logic            pd_bandgap_blk,
  output logic            pd_channel_blk
);

  // ==========================================================================
  // Serial frame capture
  logic [4:0]  bit_cnt;
  logic [23:0] shreg;
  logic        sclk_d;
  logic        rd_mode;
  logic [7:0]  rd_shift;
  logic        fuse_pend;
  logic        written;
  logic [7:0]  out_if;
  logic [7:0]  pwr_down;
  logic [2:0]  fuse_fmt_q;
  logic [2:0]  map_q;

  wire         rise       = sclk & ~sclk_d;
  wire         fall       = ~sclk & sclk_d;
  wire         active     = ~serial_select_n;
  wire [23:0]  next_shreg = {shreg[22:0], sdio_in};
  wire         word_done  = active & rise & (bit_cnt == 5'(FRAME_BITS - 1)); // RQ10
  wire [11:0]  w_addr     = next_shreg[19:8];
  wire         w_is_wr    = ~next_shreg[RW_BIT];
  wire         wr_en      = word_done & w_is_wr & ~rd_mode;
  wire         soft_rst   = wr_en & (w_addr == SOFT_RESET_OFS)
                            & next_shreg[RESET_BIT]; // RQ1
  wire         fuse_cmd   = wr_en & (w_addr == FUSE_LOAD_OFS)
                            & next_shreg[FUSE_LOAD_BIT]; // RQ3
  wire         any_rst    = rst | soft_rst;
  // Read address known once 16 header bits are in
  wire         hdr_done   = active & rise & (bit_cnt == 5'(FRAME_BITS - DATA_BITS - 1));
  wire [11:0]  r_addr     = next_shreg[11:0];
  wire         r_req      = hdr_done & next_shreg[15];

  function automatic logic [7:0] rd_mux(input logic [11:0] a);
    unique case (a)
      OUT_IF_OFS:   rd_mux = written ? out_if : OUT_IF_RST; // RQ6
      PWR_DOWN_OFS: rd_mux = pwr_down;
      default:      rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  always_ff @(posedge mclk) begin
    if (rst) begin
      // Track the pin through reset so no false edge follows release
      sclk_d  <= sclk;
      bit_cnt <= '0;
      shreg   <= '0;
      rd_mode <= 1'b0;
    end else begin
      sclk_d <= sclk;
      if (!active) begin
        bit_cnt <= '0;
        rd_mode <= 1'b0;
      end else if (rise) begin
        shreg   <= next_shreg;
        bit_cnt <= word_done ? 5'h00 : bit_cnt + 5'h01;
        if (r_req)
          rd_mode <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Readback, launched on falling serial clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_shift <= '0;
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else if (!active) begin
      sdio_oe <= 1'b0;
    end else if (r_req) begin
      rd_shift <= rd_mux(r_addr);
    end else if (fall && rd_mode && bit_cnt >= 5'(FRAME_BITS - DATA_BITS)) begin
      sdio_out <= rd_shift[7];
      sdio_oe  <= 1'b1;
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk) begin
    if (any_rst || fuse_cmd) begin // RQ1
      out_if   <= OUT_IF_RST;
      pwr_down <= PWR_DOWN_RST;
      written  <= 1'b0;
    end else if (wr_en && w_addr == OUT_IF_OFS) begin
      out_if  <= next_shreg[7:0];
      written <= 1'b1; // RQ6
    end else if (wr_en && w_addr == PWR_DOWN_OFS) begin
      // Reserved bits kept at their fixed values
      pwr_down <= (next_shreg[7:0] & PWR_DOWN_WMASK) | PWR_DOWN_RST;
    end
  end

  // Fuse load at reset release and on command; mapping latched then
  always_ff @(posedge mclk) begin
    if (rst) begin
      fuse_pend  <= 1'b1;
      fuse_fmt_q <= FMT_SDR;
      map_q      <= MAP_SDR;
    end else if (fuse_pend) begin // RQ5
      fuse_pend  <= 1'b0;
      fuse_fmt_q <= fuse_format;
      map_q      <= fuse_mapping;
    end else if (fuse_cmd) begin // RQ3
      fuse_fmt_q <= fuse_format;
      map_q      <= written ? out_if[MAP_HI:MAP_LO] : fuse_mapping; // RQ2
    end
  end

  // ==========================================================================
  // Effective outputs
  // Override field picks the format, else the fuse default
  wire ovr_en = out_if[OVR_EN_BIT];
  assign active_format  = ovr_en ? out_if[SEL_HI:SEL_LO] : fuse_fmt_q; // RQ7 RQ9 RQ8
  assign active_mapping = map_q;
  assign global_powerdown        = pwr_down[PD_GLOBAL_BIT];
  assign channel_powerdown       = pwr_down[PD_CHAN_BIT];
  assign clock_buffer_powerdown  = pwr_down[PD_CLKBUF_BIT];
  assign reference_amp_powerdown = pwr_down[PD_REFAMP_BIT];
  assign pd_clkbuf_blk  = clock_buffer_powerdown | (global_powerdown & powerdown_mask[2]); // RQ11
  assign pd_refamp_blk  = reference_amp_powerdown | (global_powerdown & powerdown_mask[1]);
  assign pd_bandgap_blk = global_powerdown & powerdown_mask[0];
  assign pd_channel_blk = channel_powerdown | global_powerdown; // RQ12

  // ==========================================================================
  // Checks
  // Register path
  soft_reset_clr_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
    soft_rst |=> out_if == OUT_IF_RST && pwr_down == PWR_DOWN_RST)
    else $error("soft reset did not restore defaults");
  soft_self_clr_a: assert property (@(posedge mclk) disable iff (rst) // RQ1
    r_req && r_addr == SOFT_RESET_OFS |=> rd_shift == 8'h00)
    else $error("soft reset bit did not read back zero");
  fmt_override_a: assert property (@(posedge mclk) disable iff (rst) // RQ9
    wr_en && w_addr == OUT_IF_OFS && !next_shreg[OVR_EN_BIT]
    |=> active_format == $past(fuse_fmt_q))
    else $error("format changed without override");
  fmt_select_a: assert property (@(posedge mclk) disable iff (rst) // RQ7
    wr_en && w_addr == OUT_IF_OFS && next_shreg[OVR_EN_BIT]
    |=> active_format == $past(next_shreg[SEL_HI:SEL_LO]))
    else $error("override not applied");
  map_hold_a: assert property (@(posedge mclk) disable iff (rst) // RQ3
    !fuse_cmd && !fuse_pend |=> $stable(map_q))
    else $error("mapping changed without fuse load");
  fuse_boot_a: assert property (@(posedge mclk) // RQ5
    $fell(rst) |-> fuse_pend ##1 !fuse_pend)
    else $error("fuse default not loaded after reset");
  boot_values_a: assert property (@(posedge mclk) disable iff (rst) // RQ5
    fuse_pend |=> map_q == $past(fuse_mapping) && fuse_fmt_q == $past(fuse_format))
    else $error("fuse defaults not captured");
  read_zero_a: assert property (@(posedge mclk) disable iff (rst) // RQ6
    r_req && r_addr == OUT_IF_OFS && !written |=> rd_shift == 8'h00)
    else $error("unwritten register read nonzero");
  // Serial port, power-down and lane mapping
  word_cnt_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
    word_done |=> bit_cnt == 5'h00)
    else $error("frame counter not reset at 24th edge");
  read_no_wr_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
    word_done && rd_mode |=> $stable(out_if) && $stable(pwr_down))
    else $error("write taken during read frame");
  oe_release_a: assert property (@(posedge mclk) disable iff (rst) // RQ10
    !active |=> !sdio_oe)
    else $error("data line driven while deselected");
  chan_pd_a: assert property (@(posedge mclk) disable iff (rst) // RQ12
    pwr_down[PD_CHAN_BIT] |-> pd_channel_blk)
    else $error("channel not powered down");
  glob_pd_a: assert property (@(posedge mclk) disable iff (rst) // RQ11
    global_powerdown && powerdown_mask[0] |-> pd_bandgap_blk)
    else $error("masked block not powered down");
  map_field_a: assert property (@(posedge mclk) disable iff (rst) // RQ2
    fuse_cmd && written |=> map_q == $past(out_if[MAP_HI:MAP_LO]))
    else $error("written mapping not applied on fuse load");

endmodule : oic_regs
`default_nettype wire

/* dv/oic_host_model.sv */
// Serial host model that drives frames into the register bank
`timescale 1ns/10ps
`default_nettype none
module oic_host_model (
  // Clock
  input  wire logic mclk,
  // Serial port
  output logic      serial_select_n,
  output logic      sclk,
  output logic      line_drv,
  input  wire logic sdio
);
  initial begin
    serial_select_n = 1'b1;
    sclk            = 1'b1;
    line_drv        = 1'b0;
  end
  // ==========================================================================
  // One 24-bit frame, MSB first, clock idles high between frames
  task automatic xfer(input logic [23:0] word, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge mclk) #1;
    serial_select_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(posedge mclk) #1;
      sclk     = 1'b0;
      // Released line toggles during readback
      line_drv = (word[23] && i < 8) ? ~line_drv : word[i];
      repeat (3) @(posedge mclk);
      #1 sclk = 1'b1;
      repeat (3) @(posedge mclk);
      if (i < 8) rd[i] = sdio;
    end
    #1 serial_select_n = 1'b1;
  endtask : xfer
endmodule : oic_host_model
`default_nettype wire

/* dv/output_interface_config_regs_tb_top.sv */
// Testbench for the output interface configuration register bank
`timescale 1ns/10ps
`default_nettype none
module output_interface_config_regs_tb_top;
  import oic_pkg::*;
  localparam logic [2:0] FUSE_FMT = 3'h4;
  localparam logic [2:0] FUSE_MAP = 3'h3;
  localparam logic [2:0] PD_MASK  = 3'h5;
  logic       mclk, rst, ssn, sclk, line_drv, sdio_out, sdio_oe;
  logic [2:0] act_fmt, act_map, pd_mask;
  logic       gpd, cpd, cbp, rap, b_clk, b_ref, b_bg, b_ch;
  wire        sdio_w;
  int         failures, total_checks;
  logic [2:0] codes [5] = '{FMT_SDR, FMT_DDR, FMT_TWO_WIRE, FMT_ONE_WIRE, FMT_HALF_WIRE};
  assign sdio_w = sdio_oe ? sdio_out : line_drv;
  oic_regs u_dut (.mclk(mclk), .rst(rst), .serial_select_n(ssn), .sclk(sclk),
    .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .fuse_format(FUSE_FMT),
    .fuse_mapping(FUSE_MAP), .powerdown_mask(pd_mask), .active_format(act_fmt),
    .active_mapping(act_map), .global_powerdown(gpd), .channel_powerdown(cpd),
    .clock_buffer_powerdown(cbp), .reference_amp_powerdown(rap), .pd_clkbuf_blk(b_clk),
    .pd_refamp_blk(b_ref), .pd_bandgap_blk(b_bg), .pd_channel_blk(b_ch));
  oic_host_model u_host (.mclk(mclk), .serial_select_n(ssn), .sclk(sclk),
    .line_drv(line_drv), .sdio(sdio_w));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================================
  // Tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] rd;
    u_host.xfer({4'h0, a, d}, rd);
    repeat (4) @(posedge mclk);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    u_host.xfer({4'h8, a, 8'h00}, rd);
    repeat (4) @(posedge mclk);
    check("readback", rd, exp);
  endtask : rd_chk
  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // ==========================================================================
  // Watchdog
  initial begin
    repeat (50000) @(posedge mclk);
    failures++;
    wrap_up();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    failures     = 0;
    total_checks = 0;
    rst          = 1'b1;
    pd_mask      = PD_MASK;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (4) @(posedge mclk);
    check("format", {5'h00, act_fmt}, {5'h00, FUSE_FMT});
    check("mapping", {5'h00, act_map}, {5'h00, FUSE_MAP});
    rd_chk(OUT_IF_OFS, OUT_IF_RST);
    rd_chk(PWR_DOWN_OFS, PWR_DOWN_RST);
    rd_chk(SOFT_RESET_OFS, 8'h00);
    for (int m = 1; m <= 6; m++) begin
      wr(OUT_IF_OFS, 8'(m << 5));
      check("mapping", {5'h00, act_map}, (m == 1) ? {5'h00, FUSE_MAP} : 8'(m - 1));
      wr(FUSE_LOAD_OFS, 8'h01);
      check("mapping", {5'h00, act_map}, 8'(m));
    end
    wr(OUT_IF_OFS, 8'h05);
    check("format", {5'h00, act_fmt}, {5'h00, FUSE_FMT});
    rd_chk(OUT_IF_OFS, 8'h05);
    foreach (codes[i]) begin
      wr(OUT_IF_OFS, {5'b00001, codes[i]});
      check("format", {5'h00, act_fmt}, {5'h00, codes[i]});
    end
    wr(PWR_DOWN_OFS, 8'h02);
    check("channel", {6'h00, cpd, b_ch}, 8'h00);
    wr(PWR_DOWN_OFS, 8'h06);
    check("channel", {6'h00, cpd, b_ch}, 8'h03);
    wr(PWR_DOWN_OFS, 8'h03);
    check("blocks", {3'h0, gpd, b_ch, b_clk, b_ref, b_bg}, {3'h0, 2'b11, PD_MASK});
    rd_chk(PWR_DOWN_OFS, 8'h03);
    #1 pd_mask = ~PD_MASK;
    @(posedge mclk);
    check("blocks", {3'h0, gpd, b_ch, b_clk, b_ref, b_bg}, {3'h0, 2'b11, ~PD_MASK});
    wr(PWR_DOWN_OFS, 8'h32);
    check("blocks", {1'b0, cbp, rap, gpd, b_ch, b_clk, b_ref, b_bg}, 8'h66);
    wr(SOFT_RESET_OFS, 8'h01);
    rd_chk(SOFT_RESET_OFS, 8'h00);
    rd_chk(OUT_IF_OFS, OUT_IF_RST);
    rd_chk(PWR_DOWN_OFS, PWR_DOWN_RST);
    check("format", {5'h00, act_fmt}, {5'h00, FUSE_FMT});
    wrap_up();
  end
endmodule : output_interface_config_regs_tb_top
`default_nettype wire
